// ### logic/adcms_top.sv
// What this block does
// - Config three bit picks input reference
// - Pin pair field selects sensor or inputs
// - Input results are 10-bit straight binary
// - Successive approximation after acquisition phase
// - High limit greater-than, low less-or-equal
// - Limits 8 bits, results 10 bits
// - Unmasked out-of-limit sets status one flag
// - Interrupt asserted on flags, selectable polarity
// - Single mode converts selected channel continuously
// - Round robin order supply, temps, inputs
// - Single mode temperatures average 16 samples
// - Averaged temperature takes about 11.4/24.16 ms
// - Config two bit five disables averaging
// - Supply result split over two bytes
// - New temperature measurement after each transaction in round robin mode
// - Transaction aborts conversion, resumes at end
// - Temperatures compared to their own limits
// - Unmasked supply out-of-limit sets status two
// - Supply uses internal reference, 7 V scale
// - Temperature range -128..127, quarter degree
// - Temperatures stored as two's complement
// - Powers up round robin, monitoring disabled
// - Mode bit enters single-channel mode
// - After input four, round robin wraps
`timescale 1ns/100ps
`default_nettype none
module adcms_top
  import adcms_pkg::*;
#(
  parameter int INT_SAMPLE_CYC = INT_SAMPLE_NS / CLK_NS,
  parameter int EXT_SAMPLE_CYC = EXT_SAMPLE_NS / CLK_NS,
  parameter int VOLT_SAMPLE_CYC = VOLT_SAMPLE_NS / CLK_NS,
  parameter int STEP_CYC = STEP_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic xfer_active,
  input wire logic cmp_input_low,
  output logic [CODE_BITS-1:0] dac_trial,
  output logic sample_hold,
  output logic [2:0] conv_channel,
  output logic ref_from_supply,
  output logic sensor_pins_ext,
  output logic int_out
);
  // ------------------------------------------------------------
  // Timing checks
  // ------------------------------------------------------------
  localparam int CONV_CYC = CODE_BITS * STEP_CYC + 1;
  localparam logic [CNT_W-1:0] INT_ACQ = CNT_W'(INT_SAMPLE_CYC - CONV_CYC);
  localparam logic [CNT_W-1:0] EXT_ACQ = CNT_W'(EXT_SAMPLE_CYC - CONV_CYC);
  localparam logic [CNT_W-1:0] VOLT_ACQ = CNT_W'(VOLT_SAMPLE_CYC - CONV_CYC);

  if (VOLT_SAMPLE_CYC <= CONV_CYC || INT_SAMPLE_CYC <= CONV_CYC ||
      EXT_SAMPLE_CYC <= CONV_CYC || EXT_SAMPLE_CYC >= 2 ** CNT_W ||
      INT_SAMPLE_CYC >= 2 ** CNT_W || VOLT_SAMPLE_CYC >= 2 ** CNT_W) begin : g_chk
    $error("Sample period does not fit the converter");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic is_temp(input adcms_ch_t ch);
    return (ch == CH_INT) || (ch == CH_EXT);
  endfunction

  function automatic adcms_ch_t next_rr(input adcms_ch_t ch, input logic ext);
    adcms_ch_t n;
    n = CH_VDD;
    unique case (ch)
      CH_VDD: n = CH_INT;
      CH_INT: n = ext ? CH_EXT : CH_ANALOG_INPUT_ONE;
      CH_EXT: n = CH_ANALOG_INPUT_THREE;
      CH_ANALOG_INPUT_ONE: n = CH_ANALOG_INPUT_TWO;
      CH_ANALOG_INPUT_TWO: n = CH_ANALOG_INPUT_THREE;
      CH_ANALOG_INPUT_THREE: n = CH_ANALOG_INPUT_FOUR;
      default: n = CH_VDD;
    endcase
    return n;
  endfunction

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] cfg3_q;
  logic [7:0] mask1_q;
  logic [7:0] mask2_q;
  logic [7:0] lim_q [NUM_LIM];
  logic [7:0] stat1_q;
  logic [7:0] stat2_q;
  logic [CODE_BITS-1:0] res_q [NUM_CH];
  logic lim_hit;
  logic [3:0] lim_idx;

  assign lim_hit = (reg_addr >= REG_LIM_BASE) && (reg_addr <= REG_LIM_LAST);
  assign lim_idx = 4'(reg_addr - REG_LIM_BASE);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg1_q <= CFG_RST;
      cfg2_q <= CFG_RST;
      cfg3_q <= CFG_RST;
      mask1_q <= CFG_RST;
      mask2_q <= CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CFG1) cfg1_q <= reg_wdata;
      if (reg_addr == REG_CFG2) cfg2_q <= reg_wdata;
      if (reg_addr == REG_CFG3) cfg3_q <= reg_wdata;
      if (reg_addr == REG_MASK1) mask1_q <= reg_wdata;
      if (reg_addr == REG_MASK2) mask2_q <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_LIM; i++) lim_q[i] <= CFG_RST;
    end else if (reg_wr && lim_hit) begin
      lim_q[lim_idx] <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  adcms_seq_t seq_q;
  adcms_ch_t rr_ch_q;
  adcms_ch_t conv_ch_q;
  adcms_ch_t sel_ch;
  adcms_ch_t pick_ch;
  logic xfer_q;
  logic xfer_fell;
  logic run_ok;
  logic single;
  logic pins_ext;
  logic conv_start;
  logic conv_busy;
  logic conv_done;
  logic conv_done_ok;
  logic [CODE_BITS-1:0] conv_code;
  logic [CNT_W-1:0] acq_sel;

  assign single = cfg2_q[CFG2_MODE];
  assign pins_ext = |cfg1_q[CFG1_PIN_MSB:CFG1_PIN_LSB];
  // Unused code seven falls back to the supply channel
  assign sel_ch = (cfg2_q[CFG2_SEL_MSB:CFG2_SEL_LSB] == 3'h7) ? CH_VDD :
                  cfg2_q[CFG2_SEL_MSB:CFG2_SEL_LSB];
  assign run_ok = cfg1_q[CFG1_EN] && !xfer_active;
  assign xfer_fell = xfer_q && !xfer_active;
  assign conv_start = (seq_q == SEQ_IDLE) && run_ok;
  assign conv_done_ok = conv_done && run_ok;
  // After a transaction the round robin restarts on a temperature
  assign pick_ch = single ? sel_ch : (xfer_fell ? CH_INT : rr_ch_q);

  always_comb begin
    unique case (pick_ch)
      CH_INT: acq_sel = INT_ACQ;
      CH_EXT: acq_sel = EXT_ACQ;
      default: acq_sel = VOLT_ACQ;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= xfer_active;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_q <= SEQ_IDLE;
    end else begin
      unique case (seq_q)
        SEQ_IDLE: if (run_ok) seq_q <= SEQ_CONV;
        SEQ_CONV: if (!run_ok || conv_done) seq_q <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_ch_q <= CH_VDD;
      rr_ch_q <= CH_VDD;
    end else begin
      if (conv_start) conv_ch_q <= pick_ch;
      if (xfer_fell) begin
        rr_ch_q <= CH_INT;
      end else if (conv_done_ok && !single) begin
        rr_ch_q <= next_rr(conv_ch_q, pins_ext);
      end
    end
  end

  adcms_sar #(
    .STEP_CYC(STEP_CYC)
  ) u_sar (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .abort(!run_ok),
    .start(conv_start),
    .acq_cyc(acq_sel),
    .cmp_input_low(cmp_input_low),
    .dac_trial(dac_trial),
    .sample_hold(sample_hold),
    .busy(conv_busy),
    .done(conv_done),
    .code(conv_code)
  );

  // ------------------------------------------------------------
  // Averaging and result store
  // ------------------------------------------------------------
  localparam int ACC_W = CODE_BITS + AVG_SHIFT;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic [3:0] avg_cnt_q;
  logic avg_active;
  logic commit;
  logic [CODE_BITS-1:0] smp_val;

  assign avg_active = single && is_temp(conv_ch_q) && !cfg2_q[CFG2_AVG_OFF];
  assign acc_sum = acc_q + {{AVG_SHIFT{conv_code[CODE_BITS-1]}}, conv_code};
  assign commit = conv_done_ok && (!avg_active || avg_cnt_q == AVG_LAST);
  assign smp_val = avg_active ? acc_sum[ACC_W-1:AVG_SHIFT] : conv_code;

  // Partial sums are dropped on abort so a stale average is never mixed
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !run_ok) begin
      acc_q <= '0;
      avg_cnt_q <= 4'h0;
    end else if (conv_done && avg_active && !commit) begin
      acc_q <= acc_sum;
      avg_cnt_q <= avg_cnt_q + 4'h1;
    end else if (conv_done) begin
      acc_q <= '0;
      avg_cnt_q <= 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) res_q[i] <= '0;
    end else if (commit) begin
      res_q[conv_ch_q] <= smp_val;
    end
  end

  // ------------------------------------------------------------
  // Limit compare and flags
  // ------------------------------------------------------------
  logic [7:0] up_lim;
  logic [7:0] lo_lim;
  logic [7:0] top8;
  logic oor;
  logic [7:0] set1;
  logic set2;
  logic rd1;
  logic rd2;
  logic any_flag;

  assign up_lim = lim_q[{conv_ch_q, 1'b0}];
  assign lo_lim = lim_q[{conv_ch_q, 1'b1}];
  assign top8 = smp_val[CODE_BITS-1:CODE_BITS-8];
  assign oor = is_temp(conv_ch_q) ?
               ($signed(top8) > $signed(up_lim) || $signed(top8) <= $signed(lo_lim)) :
               (top8 > up_lim || top8 <= lo_lim);
  assign set1 = (commit && oor && conv_ch_q != CH_VDD) ?
                ((8'h01 << (conv_ch_q - CH_INT)) & ~mask1_q) : 8'h00;
  assign set2 = commit && oor && conv_ch_q == CH_VDD && !mask2_q[STAT2_VDD];
  assign rd1 = reg_rd && reg_addr == REG_STAT1;
  assign rd2 = reg_rd && reg_addr == REG_STAT2;
  assign any_flag = |{stat1_q, stat2_q};

  // A new event in the read cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stat1_q <= 8'h00;
      stat2_q <= 8'h00;
    end else begin
      stat1_q <= (rd1 ? 8'h00 : stat1_q) | set1;
      stat2_q <= (rd2 ? 8'h00 : stat2_q) | 8'(set2);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      int_out <= 1'b1;
      ref_from_supply <= 1'b0;
      sensor_pins_ext <= 1'b0;
    end else begin
      int_out <= cfg1_q[CFG1_POL] ? any_flag : !any_flag;
      // Supply and temperatures always use the internal reference
      ref_from_supply <= cfg3_q[CFG3_REF] && !is_temp(conv_ch_q) &&
                         conv_ch_q != CH_VDD;
      sensor_pins_ext <= pins_ext;
    end
  end

  assign conv_channel = conv_ch_q;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    if (lim_hit) begin
      rd_val = lim_q[lim_idx];
    end else begin
      case (reg_addr)
        REG_STAT1: rd_val = stat1_q;
        REG_STAT2: rd_val = stat2_q;
        REG_VDD_LO: rd_val = {6'h00, res_q[CH_VDD][1:0]};
        REG_LO_A: rd_val = {res_q[CH_ANALOG_INPUT_TWO][1:0], res_q[CH_ANALOG_INPUT_ONE][1:0],
                            res_q[CH_EXT][1:0], res_q[CH_INT][1:0]};
        REG_LO_B: rd_val = {4'h0, res_q[CH_ANALOG_INPUT_FOUR][1:0], res_q[CH_ANALOG_INPUT_THREE][1:0]};
        REG_CFG1: rd_val = cfg1_q;
        REG_CFG2: rd_val = cfg2_q;
        REG_CFG3: rd_val = cfg3_q;
        REG_MASK1: rd_val = mask1_q;
        REG_MASK2: rd_val = mask2_q;
        default: begin
          if (reg_addr >= REG_HI_BASE && reg_addr <= REG_HI_LAST) begin
            rd_val = res_q[3'(reg_addr - REG_HI_BASE)][CODE_BITS-1:2];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_xfer_end;
    $fell(xfer_active) ##0 cfg1_q[CFG1_EN];
  endsequence

  AST_ABORT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    xfer_active |=> !conv_busy)
    else $error("Conversion not abandoned during transaction");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_xfer_end |-> conv_start ##1 conv_busy)
    else $error("Conversion did not resume after transaction");
  AST_TEMP_AFTER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_xfer_end ##0 !single |=> conv_channel == CH_INT)
    else $error("No temperature measurement after transaction");
  AST_DISABLED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfg1_q[CFG1_EN] |=> !conv_busy && !sample_hold)
    else $error("Converting while monitoring disabled");
  AST_SINGLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conv_start && single |=> conv_channel == $past(sel_ch))
    else $error("Single mode converted wrong channel");
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conv_done_ok && !single && conv_ch_q == CH_ANALOG_INPUT_FOUR && !xfer_fell |=> rr_ch_q == CH_VDD)
    else $error("Round robin did not wrap to supply");
  AST_VDD_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    set2 |=> stat2_q[STAT2_VDD] ##1 (stat2_q[STAT2_VDD] || $past(rd2)))
    else $error("Supply flag not raised or lost");
  AST_STICKY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stat1_q[0] && !rd1 |=> stat1_q[0])
    else $error("Status flag dropped without read");
  AST_INT_HIGH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    any_flag && cfg1_q[CFG1_POL] |=> int_out)
    else $error("Active-high interrupt not asserted");
  AST_INT_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !any_flag && !cfg1_q[CFG1_POL] |=> int_out)
    else $error("Active-low interrupt asserted without flags");
endmodule // adcms_top
`default_nettype wire

// ### common/adcms_pkg.sv
`default_nettype none
package adcms_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STAT1 = 8'h00;
  localparam logic [7:0] REG_STAT2 = 8'h01;
  localparam logic [7:0] REG_VDD_LO = 8'h03;
  localparam logic [7:0] REG_LO_A = 8'h04;
  localparam logic [7:0] REG_LO_B = 8'h05;
  localparam logic [7:0] REG_HI_BASE = 8'h06;
  localparam logic [7:0] REG_HI_LAST = 8'h0c;
  localparam logic [7:0] REG_CFG1 = 8'h18;
  localparam logic [7:0] REG_CFG2 = 8'h19;
  localparam logic [7:0] REG_CFG3 = 8'h1a;
  localparam logic [7:0] REG_MASK1 = 8'h1c;
  localparam logic [7:0] REG_MASK2 = 8'h1d;
  localparam logic [7:0] REG_LIM_BASE = 8'h25;
  localparam logic [7:0] REG_LIM_LAST = 8'h32;
  localparam logic [7:0] CFG_RST = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG1_EN = 0;
  localparam int CFG1_PIN_LSB = 1;
  localparam int CFG1_PIN_MSB = 2;
  localparam int CFG1_POL = 3;
  localparam int CFG2_SEL_LSB = 0;
  localparam int CFG2_SEL_MSB = 2;
  localparam int CFG2_MODE = 4;
  localparam int CFG2_AVG_OFF = 5;
  localparam int CFG3_REF = 4;
  localparam int STAT2_VDD = 0;
  // ------------------------------------------------------------
  // Channels and data
  // ------------------------------------------------------------
  typedef logic [2:0] adcms_ch_t;
  localparam adcms_ch_t CH_VDD = 3'h0;
  localparam adcms_ch_t CH_INT = 3'h1;
  localparam adcms_ch_t CH_EXT = 3'h2;
  localparam adcms_ch_t CH_ANALOG_INPUT_ONE = 3'h3;
  localparam adcms_ch_t CH_ANALOG_INPUT_TWO = 3'h4;
  localparam adcms_ch_t CH_ANALOG_INPUT_THREE = 3'h5;
  localparam adcms_ch_t CH_ANALOG_INPUT_FOUR = 3'h6;
  localparam int NUM_CH = 7;
  localparam int NUM_LIM = 14;
  localparam int CODE_BITS = 10;
  localparam int AVG_SHIFT = 4;
  localparam logic [3:0] AVG_LAST = 4'hf;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int INT_SAMPLE_NS = 712000;
  localparam int EXT_SAMPLE_NS = 1510000;
  localparam int VOLT_SAMPLE_NS = 20000;
  localparam int STEP_CYC_DEF = 4;
  localparam int SYNC_CYC = 3;
  localparam int CNT_W = 18;
  typedef enum logic {SEQ_IDLE, SEQ_CONV} adcms_seq_t;
endpackage
`default_nettype wire

// ### logic/adcms_sar.sv
`timescale 1ns/100ps
`default_nettype none
module adcms_sar
  import adcms_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic abort,
  input wire logic start,
  input wire logic [CNT_W-1:0] acq_cyc,
  input wire logic cmp_input_low,
  output logic [CODE_BITS-1:0] dac_trial,
  output logic sample_hold,
  output logic busy,
  output logic done,
  output logic [CODE_BITS-1:0] code
);
  typedef enum logic [1:0] {SAR_IDLE, SAR_ACQ, SAR_TRIAL} adcms_sar_t;
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);
  localparam logic [3:0] MSB_IDX = 4'(CODE_BITS - 1);

  if (STEP_CYC < SYNC_CYC) begin : g_chk
    $error("STEP_CYC too short for comparator synchroniser");
  end

  adcms_sar_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [CODE_BITS-1:0] trial_q;
  logic [CODE_BITS-1:0] code_q;
  logic [CODE_BITS-1:0] onehot;
  logic [CODE_BITS-1:0] kept;
  logic done_q;
  logic cmp_s1_q;
  logic cmp_s2_q;

  // Comparator is analog, asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_input_low;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  assign onehot = CODE_BITS'(1) << bit_q;
  assign kept = cmp_s2_q ? (trial_q & ~onehot) : trial_q;

  // Acquire, then binary search one bit per step
  always_ff @(posedge ref_clk) begin
    if (!reset_n || abort) begin
      st_q <= SAR_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      trial_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        SAR_IDLE: begin
          if (start) begin
            st_q <= SAR_ACQ;
            cnt_q <= acq_cyc;
          end
        end
        SAR_ACQ: begin
          if (cnt_q == '0) begin
            st_q <= SAR_TRIAL;
            bit_q <= MSB_IDX;
            trial_q <= CODE_BITS'(1) << MSB_IDX;
            cnt_q <= STEP_LAST;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        SAR_TRIAL: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (bit_q == 4'h0) begin
            trial_q <= kept;
            done_q <= 1'b1;
            st_q <= SAR_IDLE;
          end else begin
            trial_q <= kept | (onehot >> 1);
            bit_q <= bit_q - 4'h1;
            cnt_q <= STEP_LAST;
          end
        end
      endcase
    end
  end

  // Last code is held across aborts
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      code_q <= '0;
    end else if (!abort && st_q == SAR_TRIAL && cnt_q == '0 && bit_q == 4'h0) begin
      code_q <= kept;
    end
  end

  assign dac_trial = trial_q;
  assign sample_hold = (st_q == SAR_ACQ);
  assign busy = (st_q != SAR_IDLE);
  assign done = done_q;
  assign code = code_q;
endmodule // adcms_sar
`default_nettype wire

// ### verif/adcms_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcms_front_model
  import adcms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [CODE_BITS-1:0] dac_trial,
  input wire logic [2:0] conv_channel,
  input wire logic sample_hold,
  output logic cmp_input_low
);
  // ------------------------------------------------------------
  // Channel levels, as codes
  // ------------------------------------------------------------
  logic [CODE_BITS-1:0] level [NUM_CH];
  logic [CODE_BITS-1:0] held_q;
  logic wobble_q;
  initial begin
    wobble_q = 1'b0;
    held_q = 10'h000;
    for (int i = 0; i < NUM_CH; i++) begin
      level[i] = 10'h155;
    end
  end
  // ------------------------------------------------------------
  // Sample and compare
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    wobble_q <= !wobble_q;
    if (sample_hold) begin
      held_q <= level[conv_channel];
    end
  end
  // Balanced while acquiring, so the output is worthless then
  assign cmp_input_low = sample_hold ? wobble_q : (held_q < dac_trial);
endmodule // adcms_front_model
`default_nettype wire

// ### verif/adcms_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin \
  failures++; $display("Error at %0t: %s", $time, msg); end end
module adcms_top_bench
  import adcms_pkg::*;
;
  logic ref_clk, reset_n, reg_wr, reg_rd, xfer_active, cmp_input_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [CODE_BITS-1:0] dac_trial;
  logic sample_hold, ref_from_supply, sensor_pins_ext, int_out;
  logic [2:0] conv_channel;
  int failures = 0;
  int checks_done = 0;
  adcms_top #(.INT_SAMPLE_CYC(80), .EXT_SAMPLE_CYC(80), .VOLT_SAMPLE_CYC(60), .STEP_CYC(4))
    i_adcms_top (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .xfer_active(xfer_active),
    .cmp_input_low(cmp_input_low), .dac_trial(dac_trial), .sample_hold(sample_hold),
    .conv_channel(conv_channel), .ref_from_supply(ref_from_supply),
    .sensor_pins_ext(sensor_pins_ext), .int_out(int_out));
  adcms_front_model i_adcms_front_model (.ref_clk(ref_clk), .dac_trial(dac_trial),
    .conv_channel(conv_channel), .sample_hold(sample_hold), .cmp_input_low(cmp_input_low));
  // ------------------------------------------------------------
  // Register and conversion helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string msg);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e, msg)
    @(negedge ref_clk);
  endtask
  // Lets two cycles pass after the start so registered side outputs settle
  task automatic next_conv(output logic [2:0] ch);
    logic prev;
    bit seen;
    prev = sample_hold;
    seen = 0;
    ch = 3'h7;
    for (int n = 0; n < 400 && !seen; n++) begin
      @(negedge ref_clk);
      if (sample_hold === 1'b1 && prev === 1'b0) begin
        seen = 1;
        ch = conv_channel;
      end
      prev = sample_hold;
    end
    `CHK(seen, 1'b1, "no conversion start")
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic convs(input int n);
    logic [2:0] ch;
    repeat (n) next_conv(ch);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk_rd(REG_CFG1, 8'h00, "cfg1 reset");
    chk_rd(REG_CFG2, 8'h00, "cfg2 reset");
    chk_rd(REG_CFG3, 8'h00, "cfg3 reset");
    chk_rd(8'h1f, 8'h00, "unmapped read");
    repeat (200) begin
      @(negedge ref_clk);
      `CHK(sample_hold, 1'b0, "converting while disabled")
    end
    `CHK(int_out, 1'b1, "int level at reset")
    $display("test reset done");
  endtask
  task automatic t_robin(input logic [7:0] cfg1, input logic [2:0] e [6], input int n,
                         input logic ext);
    logic [2:0] ch;
    wr(REG_CFG3, 8'h10);
    wr(REG_CFG2, 8'h00);
    wr(REG_CFG1, cfg1);
    ch = 3'h7;
    for (int i = 0; i < 8 && ch !== CH_VDD; i++) next_conv(ch);
    for (int i = 1; i < n; i++) begin
      next_conv(ch);
      `CHK(ch, e[i], "round robin order")
      `CHK(ref_from_supply, (ch >= CH_ANALOG_INPUT_ONE), "reference choice")
    end
    next_conv(ch);
    `CHK(ch, CH_VDD, "wrap after input four")
    `CHK(sensor_pins_ext, ext, "pin pair use")
    $display("test round robin %0h done", cfg1);
  endtask
  task automatic t_single(input logic [2:0] sel, input logic [2:0] e);
    logic [2:0] ch;
    wr(REG_CFG2, {5'h02, sel});
    convs(1);
    repeat (3) begin
      next_conv(ch);
      `CHK(ch, e, "single channel")
    end
    $display("test single %0h done", sel);
  endtask
  task automatic t_limits();
    wr(REG_MASK1, 8'h3f);
    wr(REG_MASK2, 8'h00);
    wr(REG_LIM_BASE, 8'hb7);
    wr(REG_LIM_BASE + 8'h01, 8'h00);
    chk_rd(REG_STAT1, 8'h3f, "flags latched from open limits");
    chk_rd(REG_STAT2, 8'h01, "supply flag latched");
    convs(2);
    chk_rd(REG_VDD_LO, 8'h02, "supply low bits");
    chk_rd(REG_HI_BASE, 8'hb7, "supply high byte");
    chk_rd(REG_STAT1, 8'h00, "masked flags");
    chk_rd(REG_STAT2, 8'h00, "equal to upper limit");
    convs(2);
    chk_rd(REG_STAT2, 8'h00, "equal to upper limit");
    `CHK(int_out, 1'b1, "int idle")
    wr(REG_LIM_BASE + 8'h01, 8'hb7);
    convs(2);
    `CHK(int_out, 1'b0, "equal to lower limit")
    wr(REG_LIM_BASE + 8'h01, 8'h00);
    convs(2);
    `CHK(int_out, 1'b0, "flag held")
    chk_rd(REG_STAT2, 8'h01, "supply flag");
    repeat (3) @(negedge ref_clk);
    `CHK(int_out, 1'b1, "int released")
    chk_rd(REG_STAT2, 8'h00, "flag cleared");
    wr(REG_CFG1, 8'h09);
    repeat (3) @(negedge ref_clk);
    `CHK(int_out, 1'b0, "active high idle")
    wr(REG_LIM_BASE, 8'h00);
    convs(2);
    `CHK(int_out, 1'b1, "active high asserted")
    $display("test limits done");
  endtask
  task automatic t_abort();
    logic [2:0] ch;
    wr(REG_CFG2, 8'h00);
    convs(3);
    xfer_active = 1'b1;
    repeat (20) begin
      @(negedge ref_clk);
    end
    repeat (60) begin
      @(negedge ref_clk);
      `CHK(sample_hold, 1'b0, "converter stopped")
    end
    xfer_active = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(sample_hold, 1'b1, "restart after transfer")
    `CHK(conv_channel, CH_INT, "temperature first")
    $display("test abort done");
  endtask
  // Averaging holds the old result until sixteen samples are in
  task automatic t_temp();
    wr(REG_CFG1, 8'h08);
    i_adcms_front_model.level[1] = 10'h3f0;
    wr(REG_MASK1, 8'h3e);
    wr(REG_LIM_BASE + 8'h02, 8'h00);
    wr(REG_LIM_BASE + 8'h03, 8'h80);
    wr(REG_CFG2, 8'h11);
    `CHK(sample_hold, 1'b0, "idle while disabled")
    wr(REG_CFG1, 8'h09);
    convs(3);
    chk_rd(REG_HI_BASE + 8'h01, 8'h55, "average still running");
    convs(14);
    chk_rd(REG_HI_BASE + 8'h01, 8'hfc, "averaged negative temperature");
    chk_rd(REG_STAT1, 8'h00, "signed limits kept");
    wr(REG_LIM_BASE + 8'h03, 8'hfc);
    wr(REG_CFG2, 8'h31);
    convs(2);
    chk_rd(REG_STAT1, 8'h01, "temperature at lower limit");
    $display("test temperature done");
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Whole run needs about 4500 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    xfer_active = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    i_adcms_front_model.level[0] = 10'h2de;
    @(negedge ref_clk);
    t_reset();
    t_robin(8'h01, '{CH_VDD, CH_INT, CH_ANALOG_INPUT_ONE, CH_ANALOG_INPUT_TWO, CH_ANALOG_INPUT_THREE, CH_ANALOG_INPUT_FOUR}, 6, 1'b0);
    t_robin(8'h03, '{CH_VDD, CH_INT, CH_EXT, CH_ANALOG_INPUT_THREE, CH_ANALOG_INPUT_FOUR, CH_VDD}, 5, 1'b1);
    t_single(3'h1, CH_INT);
    t_single(3'h0, CH_VDD);
    t_limits();
    t_abort();
    t_temp();
    close_out();
  end
endmodule // adcms_top_bench
`default_nettype wire
